// File: strap_pkg.sv
// Shared constants, types and register map for the strap and debug pin block
package strap_pkg;

  // Wishbone register byte offsets
  localparam logic [7:0] strap_status_off  = 8'h00;
  localparam logic [7:0] debug_enable_off  = 8'h04;
  localparam logic [7:0] boot_control_off  = 8'h08;
  localparam logic [7:0] pin_control_off   = 8'h0c;
  localparam logic [7:0] wake_enable_off   = 8'h10;
  localparam logic [7:0] otp_options_off   = 8'h14;

  // Strap status field positions
  localparam int st_tap_bit      = 0;
  localparam int st_recovery_bit = 1;
  localparam int st_comp_bit     = 2;
  localparam int st_serial_bit   = 3;
  localparam int st_port_bit     = 4;
  localparam int st_mode_lsb     = 8;

  // Boot control field positions
  localparam int bc_flash_sel_bit = 0;
  localparam int bc_dsw_pgood_bit = 1;
  localparam int bc_cmp_lock_bit  = 2;
  localparam int bc_cmp_en_bit    = 3;

  // OTP option positions: comparator strap enable, serial recovery enable, port select
  localparam int otp_cmp_en_bit    = 0;
  localparam int otp_serial_en_bit = 1;
  localparam int otp_port_sel_bit  = 3;

  // Reset values
  localparam logic [2:0] debug_enable_rst = 3'h0;
  localparam logic [7:0] pin_control_rst  = 8'h00;
  localparam logic [7:0] wake_enable_rst  = 8'hff;

  // Pin control: bit 7 picks the keyboard segment; pin routing ignores it, mux_gpio unused
  localparam logic [1:0] mux_gpio = 2'h0;

  // Debug modes taken from debug enable bits [2:0]
  typedef enum logic [2:0] {
    dbg_off   = 3'b000,
    dbg_jtag4 = 3'b001,
    dbg_jtag2 = 3'b010,
    dbg_swd   = 3'b011,
    dbg_swv   = 3'b100
  } debug_mode_e;

  // Decoded strap set held from reset release
  typedef struct packed {
    logic tap_boundary_scan;
    logic recovery_boot;
    logic comparator_enable;
    logic serial_recovery;
    logic serial_port_sel;
  } strap_s;

  // Debug port pin bundle: clk, mode select, data in, data out
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
  } dbg_pins_s;

endpackage

// File: pin_route_cell.sv
// One shared pin: chooses between debug function and GPIO function
`timescale 1ns/1ns
module pin_route_cell
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic dbg_use,
  input  wire logic dbg_out,
  input  wire logic dbg_oe,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  output logic      pin_out,
  output logic      pin_oe
);

  // Registered mux so the pin outputs come straight from flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else if (dbg_use)
    begin
      pin_out <= dbg_out;
      pin_oe  <= dbg_oe;
    end
    else
    begin
      pin_out <= gpio_out;
      pin_oe  <= gpio_oe;
    end
  end

endmodule

// File: strap_debug_mux.sv
// Strap capture, debug pin routing and boot pin control behind Wishbone
`timescale 1ns/1ns
module strap_debug_mux
  import strap_pkg::*;
#(
  parameter int npins = 4
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Wishbone classic slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  // Strap pins
  input  wire logic               tap_strap_pin,
  input  wire logic               recovery_strap_pin,
  input  wire logic               comparator_strap_pin,
  input  wire logic               serial_recovery_strap_pin,
  // Debug port select, high active
  input  wire logic               debug_select_n,
  // Internal debug core side
  input  wire strap_pkg::dbg_pins_s dbg_core_out,
  input  wire strap_pkg::dbg_pins_s dbg_core_oe,
  output strap_pkg::dbg_pins_s    dbg_core_in,
  // GPIO side of the shared debug pins
  input  wire logic [npins-1:0]   gpio_out,
  input  wire logic [npins-1:0]   gpio_oe,
  input  wire logic [npins-1:0]   pad_in,
  output logic [npins-1:0]        pad_out,
  output logic [npins-1:0]        pad_oe,
  // Boot pins and monitors
  input  wire logic               clk_48_en,
  output logic                    shared_flash_select0_n,
  output logic                    deep_sleep_well_power_good,
  output logic                    comparator0_enable,
  output logic                    test_clock_monitor_out,
  output logic [7:0]              wake_input_enable_reg,
  output logic [1:0]              kbd_segment_sel
);

  strap_s      strap_q;
  logic        captured_q;
  logic [2:0]  debug_enable_q;
  logic [7:0]  pin_control_q;
  logic [3:0]  boot_control_q;
  logic [3:0]  otp_options_q;
  logic        cmp_locked_q;
  logic        dbg_route;
  debug_mode_e mode;
  logic [npins-1:0] dbg_use;
  logic [npins-1:0] dbg_o;
  logic [npins-1:0] dbg_e;
  logic        wr_stb;
  logic        rd_hit;
  logic [31:0] rd_data;

  // One-time strap capture on the first clock after reset release
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_q    <= '0;
      captured_q <= 1'b0;
    end
    else if (!captured_q)
    begin
      captured_q                <= 1'b1;
      strap_q.tap_boundary_scan <= tap_strap_pin;
      strap_q.recovery_boot     <= ~recovery_strap_pin;
      strap_q.comparator_enable <= comparator_strap_pin;
      strap_q.serial_recovery   <= ~serial_recovery_strap_pin;
      strap_q.serial_port_sel   <= 1'b0;
    end
    else if (strap_q.serial_recovery)
    begin
      // Port choice follows the OTP option bit while recovery is strapped
      strap_q.serial_port_sel <= otp_options_q[otp_port_sel_bit];
    end
  end

  // Write strobe: classic Wishbone, one access per ack
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_o;

  // Software registers; each write respects its byte lane
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      debug_enable_q        <= debug_enable_rst;
      pin_control_q         <= pin_control_rst;
      wake_input_enable_reg <= wake_enable_rst;
      otp_options_q         <= 4'h0;
    end
    else if (wr_stb && sel_i[0])
    begin
      case (adr_i)
        debug_enable_off: debug_enable_q <= dat_i[2:0];
        pin_control_off:  pin_control_q <= dat_i[7:0];
        wake_enable_off:  wake_input_enable_reg <= dat_i[7:0];
        otp_options_off:  otp_options_q <= dat_i[3:0];
        default:          ;
      endcase
    end
  end

  // Boot pin drive and comparator lock; lock holds until reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_control_q <= 4'h0;
      cmp_locked_q   <= 1'b0;
    end
    else if (wr_stb && sel_i[0] && adr_i == boot_control_off)
    begin
      boot_control_q[bc_flash_sel_bit] <= dat_i[bc_flash_sel_bit];
      boot_control_q[bc_dsw_pgood_bit] <= dat_i[bc_dsw_pgood_bit];
      if (!cmp_locked_q && otp_options_q[otp_cmp_en_bit])
      begin
        // Comparator takes the strap value, then freezes if the write sets the lock bit
        boot_control_q[bc_cmp_en_bit] <= strap_q.comparator_enable;
        cmp_locked_q                  <= dat_i[bc_cmp_lock_bit];
      end
    end
  end

  // Flash select is active low: drive high once boot code sets the bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shared_flash_select0_n     <= 1'b0;
      deep_sleep_well_power_good <= 1'b0;
      comparator0_enable         <= 1'b0;
    end
    else
    begin
      shared_flash_select0_n     <= boot_control_q[bc_flash_sel_bit];
      deep_sleep_well_power_good <= boot_control_q[bc_dsw_pgood_bit];
      // Without the OTP option the strap has no effect at all
      comparator0_enable <= otp_options_q[otp_cmp_en_bit] &
                            boot_control_q[bc_cmp_en_bit];
    end
  end

  // Keyboard segment: only one may point at the controller
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      kbd_segment_sel <= 2'h0;
    else
      kbd_segment_sel <= pin_control_q[7] ? 2'b10 : 2'b01;
  end

  // Monitor output toggles on each 48MHz enable; stops when it stops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      test_clock_monitor_out <= 1'b0;
    else if (clk_48_en)
      test_clock_monitor_out <= ~test_clock_monitor_out;
  end

  // Debug routing: the select input alone connects the debug port
  assign dbg_route = debug_select_n;
  assign mode      = debug_mode_e'(debug_enable_q);

  // Which pins each debug mode claims; pin order tck, tms, tdi, tdo
  always_comb
  begin
    dbg_use = '0;
    dbg_o   = {dbg_core_out.tck, dbg_core_out.tms, dbg_core_out.tdi, dbg_core_out.tdo};
    dbg_e   = {dbg_core_oe.tck, dbg_core_oe.tms, dbg_core_oe.tdi, dbg_core_oe.tdo};
    if (dbg_route)
    begin
      case (mode)
        dbg_off:   dbg_use = 4'b1111;
        dbg_jtag4: dbg_use = 4'b1111;
        dbg_jtag2: dbg_use = 4'b0101;
        dbg_swd:   dbg_use = 4'b1100;
        dbg_swv:   dbg_use = 4'b1101;
        default:   dbg_use = 4'b1111;
      endcase
    end
  end

  // Inputs seen by the debug core; unrouted pins read as idle high
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      dbg_core_in <= '1;
    else
      dbg_core_in <= {dbg_use[3] ? pad_in[3] : 1'b1, dbg_use[2] ? pad_in[2] : 1'b1,
                      dbg_use[1] ? pad_in[1] : 1'b1, dbg_use[0] ? pad_in[0] : 1'b1};
  end

  // Per-pin routing cells; pin control has no path onto the debug leg
  for (genvar i = 0; i < npins; i++)
  begin : g_pin
    pin_route_cell u_cell
    (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .dbg_use  (dbg_use[i]),
      .dbg_out  (dbg_o[i]),
      .dbg_oe   (dbg_e[i]),
      .gpio_out (gpio_out[i]),
      .gpio_oe  (gpio_oe[i]),
      .pin_out  (pad_out[i]),
      .pin_oe   (pad_oe[i])
    );
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (adr_i)
      strap_status_off:
      begin
        rd_data[st_tap_bit]      = strap_q.tap_boundary_scan;
        rd_data[st_recovery_bit] = strap_q.recovery_boot;
        rd_data[st_comp_bit]     = strap_q.comparator_enable & otp_options_q[otp_cmp_en_bit];
        rd_data[st_serial_bit]   = strap_q.serial_recovery & otp_options_q[otp_serial_en_bit];
        rd_data[st_port_bit]     = strap_q.serial_port_sel;
        rd_data[st_mode_lsb+:3]  = debug_enable_q;
        rd_data[st_mode_lsb+3]   = debug_select_n;
      end
      debug_enable_off: rd_data[2:0] = debug_enable_q;
      boot_control_off: rd_data[3:0] = {boot_control_q[3], cmp_locked_q, boot_control_q[1:0]};
      pin_control_off:  rd_data[7:0] = pin_control_q;
      wake_enable_off:  rd_data[7:0] = wake_input_enable_reg;
      otp_options_off:  rd_data[3:0] = otp_options_q;
      default:          rd_hit = 1'b0;
    endcase
  end

  // Ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= (rd_hit && !we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // Straps stay fixed once captured; only the port choice may follow its option
  a_strap_hold_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
    captured_q && $past(captured_q) |-> strap_q[4:1] == $past(strap_q[4:1]))
    else $error("strap changed after capture");

  // Select low removes every debug claim from the pins
  a_no_dbg_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !debug_select_n |-> dbg_use == '0)
    else $error("debug routed while select low");

  // Select high claims pins regardless of pin control
  a_dbg_high_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_select_n && mode == dbg_jtag4 |-> ##1 pad_oe == $past(dbg_e))
    else $error("debug not routed while select high");

  // Two-pin mode claims only mode-select and data-out
  a_two_pin_use: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_select_n && mode == dbg_jtag2 |-> dbg_use == 4'b0101)
    else $error("two-pin mode pin set wrong");

  // Serial wire debug claims clock and data line
  a_swd_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_select_n && mode == dbg_swd |-> dbg_use == 4'b1100)
    else $error("swd pin set wrong");

  // Viewer mode claims clock, mode select, data out
  a_swv_pins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    debug_select_n && mode == dbg_swv |-> dbg_use == 4'b1101)
    else $error("swv pin set wrong");

  // Comparator stays off without the OTP option
  a_cmp_gated_otp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !otp_options_q[otp_cmp_en_bit] |=> !comparator0_enable)
    else $error("comparator on without option");

  // Monitor toggles one cycle after each 48MHz enable
  a_mon_toggle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_48_en |=> test_clock_monitor_out != $past(test_clock_monitor_out))
    else $error("monitor did not toggle");

  // Keyboard segments never both active
  a_kbd_one_seg: assert property (@(posedge clk_sys) disable iff (!rst_b)
    kbd_segment_sel != 2'b11)
    else $error("both keyboard segments active");

  // Flash select follows boot control two cycles after write
  sequence s_flash_write;
    wr_stb && sel_i[0] && adr_i == boot_control_off && dat_i[bc_flash_sel_bit];
  endsequence
  a_flash_sel_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_flash_write |-> ##2 shared_flash_select0_n)
    else $error("flash select not driven high");

  // Recovery port choice tracks its option bit while recovery is strapped
  a_port_sel_opt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    captured_q && strap_q.serial_recovery |=> strap_q.serial_port_sel ==
    $past(otp_options_q[otp_port_sel_bit]))
    else $error("recovery port not taken from option");

  // Power good pin is its boot control bit one cycle later
  a_dsw_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    captured_q |=> deep_sleep_well_power_good == $past(boot_control_q[bc_dsw_pgood_bit]))
    else $error("power good pin lags its control bit");

endmodule

// File: probe_model.sv
// Board model: strap resistors and debug probe pull-ups on shared pins
`timescale 1ns/1ns
module probe_model
(
  input  wire logic [3:0] strap_lv,
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe,
  output logic            tap_strap_pin,
  output logic            recovery_strap_pin,
  output logic            comparator_strap_pin,
  output logic            serial_recovery_strap_pin,
  output logic [3:0]      pad_in
);
  // Strap resistors; tap strap pin only ever an output to board logic
  assign tap_strap_pin = strap_lv[3];
  assign recovery_strap_pin = strap_lv[2];
  assign comparator_strap_pin = strap_lv[1];
  assign serial_recovery_strap_pin = strap_lv[0];
  // Undriven pins float to the probe pull-ups, never keep the old level
  assign pad_in = (pad_out & pad_oe) | ~pad_oe;
endmodule

// File: strap_debug_mux_test.sv
// Self-checking bench for strap capture, debug routing and boot pins
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t got %h exp %h", $time, a, b); end end
module strap_debug_mux_test;
  import strap_pkg::*;
  typedef struct packed {logic s; logic [2:0] m; logic [7:0] pc; logic [3:0] k;} row_s;
  logic        clk_sys, rst_b, cyc, stb, we, ack, clk48, flash_n, dsw, cmp0, tmon, sel_n, prev;
  logic [7:0]  adr, wake;
  logic [3:0]  sel, strap_lv, pad_in, pad_out, pad_oe, g_out, g_oe, eo, ee;
  logic [1:0]  kbd;
  logic [31:0] wdat, dat_o, rd;
  logic        tp, rp, cp, sp;
  dbg_pins_s   c_out, c_oe, c_in;
  int          checks, bad_count;
  // Mode rows: select level, enable bits, pin control, routed pin mask
  row_s rows [0:7] = '{'{1'b1, 3'd0, 8'h00, 4'hf}, '{1'b1, 3'd1, 8'h00, 4'hf},
    '{1'b1, 3'd2, 8'h00, 4'h5}, '{1'b1, 3'd3, 8'h00, 4'hc}, '{1'b1, 3'd4, 8'h00, 4'hd},
    '{1'b1, 3'd1, 8'h80, 4'hf}, '{1'b0, 3'd1, 8'h00, 4'h0}, '{1'b0, 3'd3, 8'h00, 4'h0}};

  strap_debug_mux #(.npins(4)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack), .tap_strap_pin(tp), .recovery_strap_pin(rp), .comparator_strap_pin(cp),
    .serial_recovery_strap_pin(sp), .debug_select_n(sel_n), .dbg_core_out(c_out),
    .dbg_core_oe(c_oe), .dbg_core_in(c_in), .gpio_out(g_out), .gpio_oe(g_oe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .clk_48_en(clk48),
    .shared_flash_select0_n(flash_n), .deep_sleep_well_power_good(dsw),
    .comparator0_enable(cmp0), .test_clock_monitor_out(tmon),
    .wake_input_enable_reg(wake), .kbd_segment_sel(kbd));

  probe_model board (.strap_lv(strap_lv), .pad_out(pad_out), .pad_oe(pad_oe),
    .tap_strap_pin(tp), .recovery_strap_pin(rp), .comparator_strap_pin(cp),
    .serial_recovery_strap_pin(sp), .pad_in(pad_in));

  // Free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Classic cycle; request held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clk_sys);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // One more edge: ack must drop and registered outputs settle
    @(posedge clk_sys);
    `CHK(ack, 1'b0)
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  // Reset values checked while reset is held
  task do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(c_in, 4'hf)
    `CHK(wake, wake_enable_rst)
    `CHK({flash_n, dsw, cmp0, ack}, 4'h0)
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(kbd, 2'b01)
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected two hundred or so cycles
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end

  initial
  begin
    {cyc, stb, we, clk48, sel_n, rst_b} = 6'h1;
    {adr, sel, wdat} = '0;
    strap_lv = 4'b1010;
    g_out = 4'b0110;
    g_oe = 4'b0011;
    c_out = 4'b1010;
    c_oe = 4'b1100;
    do_reset();
    bus(1'b0, strap_status_off, 32'h0, 4'hf);
    `CHK(rd & 32'h0b, 32'h03)
    strap_lv <= 4'b0101;
    bus(1'b0, strap_status_off, 32'h0, 4'hf);
    `CHK(rd & 32'h0b, 32'h03)
    // Serial recovery shows once its option is on; port bit from the option
    wr(otp_options_off, 32'ha);
    bus(1'b0, strap_status_off, 32'h0, 4'hf);
    `CHK(rd[3], 1'b1)
    `CHK(rd[4], 1'b1)
    // Comparator: ignored without option, loaded with it, then locked
    wr(otp_options_off, 32'h0);
    wr(boot_control_off, 32'h4);
    `CHK(cmp0, 1'b0)
    wr(otp_options_off, 32'h1);
    wr(boot_control_off, 32'h4);
    `CHK(cmp0, 1'b1)
    wr(boot_control_off, 32'h0);
    bus(1'b0, boot_control_off, 32'h0, 4'hf);
    `CHK(rd[3:2], 2'b11)
    wr(otp_options_off, 32'h0);
    `CHK(cmp0, 1'b0)
    // Boot pins; a write with lane 0 disabled must not land
    bus(1'b1, boot_control_off, 32'h3, 4'he);
    `CHK({flash_n, dsw}, 2'b00)
    wr(boot_control_off, 32'h3);
    `CHK(flash_n, 1'b1)
    `CHK(dsw, 1'b1)
    wr(wake_enable_off, 32'h0);
    bus(1'b0, wake_enable_off, 32'h0, 4'hf);
    `CHK(rd[7:0], 8'h00)
    `CHK(wake, 8'h00)
    // Unmapped offset reads zero and ignores writes
    wr(8'h1c, 32'hff);
    bus(1'b0, 8'h1c, 32'h0, 4'hf);
    `CHK(rd, 32'h0)
    foreach (rows[i])
    begin
      sel_n <= rows[i].s;
      wr(debug_enable_off, {29'h0, rows[i].m});
      wr(pin_control_off, {24'h0, rows[i].pc});
      repeat (3) @(posedge clk_sys);
      eo = (c_out & rows[i].k) | (g_out & ~rows[i].k);
      ee = (c_oe & rows[i].k) | (g_oe & ~rows[i].k);
      `CHK(pad_out, eo)
      `CHK(pad_oe, ee)
      `CHK(c_in, ((eo & ee) | ~ee) | ~rows[i].k)
      `CHK(kbd, rows[i].pc[7] ? 2'b10 : 2'b01)
    end
    // Alternate pin control values must not reach the debug core
    wr(pin_control_off, 32'h7f);
    repeat (3) @(posedge clk_sys);
    `CHK(c_in, 4'hf)
    `CHK(pad_out, g_out)
    `CHK(pad_oe, g_oe)
    for (int k = 0; k < 3; k++)
    begin
      prev = tmon;
      clk48 <= 1'b1;
      @(posedge clk_sys);
      clk48 <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK(tmon, ~prev)
    end
    do_reset();
    bus(1'b0, strap_status_off, 32'h0, 4'hf);
    `CHK(rd & 32'h0b, 32'h0)
    `CHK(cmp0, 1'b0)
    conclude();
  end
endmodule
